/* File: hub_i2c_pkg.sv */
package hub_i2c_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int STRAP_WAIT_MS = 1;
   localparam int STRAP_WAIT_CYCLES = STRAP_WAIT_MS * 1000000 / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // register offsets (8-bit register pointer space)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PRIMARY = 8'h00;
   localparam logic [7:0] OFS_GENERAL = 8'h02;
   localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
   localparam logic [7:0] OFS_LINK_STATUS = 8'h4D;
   localparam logic [7:0] OFS_BACK_CHAN = 8'h58;
   localparam logic [7:0] OFS_ALIAS = 8'h5C;
   localparam logic [7:0] OFS_PORT0_ADDR = 8'hF8;
   localparam logic [7:0] OFS_PORT1_ADDR = 8'hF9;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int GEN_PROXY_BIT = 5;
   localparam int BCC_PASS_BIT = 6;
   localparam int BCC_RATE_LSB = 0;
   localparam int BCC_RATE_MSB = 1;
   localparam int PORT_SEL_BIT = 0;
   localparam logic [1:0] RATE_STRAP = 2'h0;
   localparam logic [1:0] RATE_SLOW = 2'h1;
   localparam logic [1:0] RATE_FAST = 2'h2;
   localparam logic [7:0] RST_PRIMARY = 8'h60;
   localparam logic [7:0] RST_GENERAL = 8'h00;
   localparam logic [7:0] RST_PORT_SEL = 8'h00;
   localparam logic [7:0] RST_BACK_CHAN = 8'h00;
   localparam logic [7:0] RST_ALIAS = 8'h00;
   localparam logic [7:0] RST_PORT_ADDR = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RECV = 6'h02,
      ST_ACK = 6'h04,
      ST_SEND = 6'h08,
      ST_MACK = 6'h10,
      ST_WAIT = 6'h20
   } state_type;

   // one byte handed to the side control channel
   typedef struct packed {
      logic port;
      logic start;
      logic read;
      logic [7:0] data;
   } fwd_req_type;

   // strap level index to 8-bit target address (7-bit shifted left)
   function automatic logic [7:0] strap_to_addr(input logic [2:0] idx);
      logic [6:0] a;
      a = 7'h30;
      case (idx)
         3'h0: a = 7'h30;
         3'h1: a = 7'h32;
         3'h2: a = 7'h34;
         3'h3: a = 7'h36;
         3'h4: a = 7'h38;
         3'h5: a = 7'h3A;
         3'h6: a = 7'h3C;
         3'h7: a = 7'h3D;
         default: a = 7'h30;
      endcase
      return {a, 1'b0};
   endfunction

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [WIDTH-1:0] D,
   output logic [WIDTH-1:0] Q
);
   import hub_i2c_pkg::*;

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = D;
      next_q = meta;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         meta <= '0;
         Q <= '0;
      end else if (CE) begin
         meta <= next_meta;
         Q <= next_q;
      end
   end
endmodule

/* File: strap_sampler.sv */
`timescale 1ns/1ps
// waits after power-down release, then latches the address strap
module strap_sampler #(
   parameter int WAIT_CYCLES = hub_i2c_pkg::STRAP_WAIT_CYCLES
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic RELEASE,
   input wire logic [2:0] STRAP_IDX,
   output logic LOAD,
   output logic [7:0] ADDR
);
   import hub_i2c_pkg::*;

   logic [31:0] count;
   logic done;
   logic [31:0] next_count;
   logic next_done;
   logic next_load;
   logic [7:0] next_addr;

   // counting restarts whenever the power-down pin drops again
   always_comb begin
      next_count = count;
      next_done = done;
      next_load = 1'b0;
      next_addr = ADDR;
      if (!RELEASE) begin
         next_count = '0;
         next_done = 1'b0;
      end else if (!done) begin
         if (count == 32'(WAIT_CYCLES - 1)) begin
            next_done = 1'b1;
            next_load = 1'b1;
            next_addr = strap_to_addr(STRAP_IDX);
         end else begin
            next_count = count + 32'h1;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         count <= '0;
         done <= 1'b0;
         LOAD <= 1'b0;
         ADDR <= RST_PRIMARY;
      end else if (CE) begin
         count <= next_count;
         done <= next_done;
         LOAD <= next_load;
         ADDR <= next_addr;
      end
   end

   chk_strap_wait_time: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(LOAD) |-> $past(count) == 32'(WAIT_CYCLES - 1) && $past(RELEASE))
      else $error("strap sampled before the release wait ended");
   chk_strap_addr_map: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(LOAD) |-> ADDR == strap_to_addr($past(STRAP_IDX)))
      else $error("strap index mapped to wrong address");
endmodule

/* File: hub_i2c_control_port.sv */
`timescale 1ns/1ps
// Behaviour
// - i2c target, standard to fast-plus, 1 MHz
// - combined write then repeated-start read accepted
// - never stretch clock for local registers
// - stretch clock until remote response returns
// - proxy controller runs only when 0x02[5] set
// - local register access plus traffic across link
// - back channel carries gpio and capabilities
// - rate from mode strap, per-port 0x58 override
// - two back-channel rates, 50 and 2.5 Mbps
// - sample address strap 1 ms after release
// - primary address kept in register 0x00
// - two per-port addresses reach port registers
// - per-port addresses also reach shared registers
// - per-port addresses at 0xF8 and 0xF9
// - strap index selects address 0x30 to 0x3D
// - forwarding only when 0x58 bit 6 set
module hub_i2c_control_port #(
   parameter int STRAP_WAIT = hub_i2c_pkg::STRAP_WAIT_CYCLES,
   parameter int GPIO_W = 4,
   parameter logic [7:0] CAPS = 8'h5A // arbitrary capability code
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic POWER_DOWN_RELEASE_PIN,
   input wire logic [2:0] ADDRESS_STRAP_PIN,
   input wire logic MODE_STRAP_PIN,
   input wire logic [1:0] PORT_LOCK,
   input wire logic [GPIO_W-1:0] GPIO_IN,
   output logic FWD_REQ,
   output hub_i2c_pkg::fwd_req_type FWD,
   input wire logic FWD_DONE,
   input wire logic FWD_ACK,
   input wire logic [7:0] FWD_RDATA,
   output logic [GPIO_W-1:0] BC_GPIO,
   output logic [7:0] BC_CAPS,
   output logic [1:0] BC_RATE_FAST,
   output logic PROXY_EN
);
   import hub_i2c_pkg::*;

   localparam int SW = 7 + GPIO_W;

   // ----------------------------------------------------------------
   // pin synchronisers and strap capture
   // ----------------------------------------------------------------
   logic [SW-1:0] pins;
   logic scl_s, sda_s, rel_s, mode_s;
   logic [2:0] idx_s;
   logic [GPIO_W-1:0] gpio_s;
   logic strap_load;
   logic [7:0] strap_addr;

   pin_sync #(.WIDTH(SW)) u_sync (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .CE(CE),
      .D({GPIO_IN, ADDRESS_STRAP_PIN, MODE_STRAP_PIN,
          POWER_DOWN_RELEASE_PIN, SDA_IN, SCL_IN}),
      .Q(pins)
   );
   assign {gpio_s, idx_s, mode_s, rel_s, sda_s, scl_s} = pins;

   strap_sampler #(.WAIT_CYCLES(STRAP_WAIT)) u_strap (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .CE(CE),
      .RELEASE(rel_s),
      .STRAP_IDX(idx_s),
      .LOAD(strap_load),
      .ADDR(strap_addr)
   );

   // ----------------------------------------------------------------
   // protocol and register state
   // ----------------------------------------------------------------
   state_type state, next_state;
   logic scl_q, sda_q;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sh, next_sh, tx, next_tx, ptr, next_ptr;
   logic first, next_first, ptr_phase, next_ptr_phase;
   logic rd, next_rd, fwd, next_fwd, ack, next_ack;
   logic via_pp, next_via_pp, pp_idx, next_pp_idx;
   logic after_send, next_after_send;
   logic next_req;
   fwd_req_type next_fwd_data;
   logic [7:0] prim, next_prim, gen, next_gen, psel, next_psel;
   logic [7:0] bcc [2];
   logic [7:0] next_bcc [2];
   logic [7:0] alias_addr [2];
   logic [7:0] next_alias [2];
   logic [7:0] paddr [2];
   logic [7:0] next_paddr [2];
   logic rise, fall, start_det, stop_det;
   logic port_idx, sel_port;
   logic [7:0] rd_val;

   // compare a received address byte against an 8-bit form register
   function automatic logic addr_hit(input logic [7:0] b,
                                     input logic [7:0] r);
      return (r[7:1] != 7'h00) && (b[7:1] == r[7:1]);
   endfunction

   assign rise = scl_s && !scl_q;
   assign fall = !scl_s && scl_q;
   assign start_det = scl_s && scl_q && sda_q && !sda_s;
   assign stop_det = scl_s && scl_q && !sda_q && sda_s;
   assign sel_port = psel[PORT_SEL_BIT];
   // paged registers follow the per-port address when one was used
   assign port_idx = via_pp ? pp_idx : sel_port;

   // register read mux; unmapped offsets read zero
   always_comb begin
      rd_val = 8'h00;
      case (ptr)
         OFS_PRIMARY: rd_val = prim;
         OFS_GENERAL: rd_val = gen;
         OFS_PORT_SEL: rd_val = psel;
         OFS_LINK_STATUS: rd_val = {6'h00, PORT_LOCK};
         OFS_BACK_CHAN: rd_val = bcc[port_idx];
         OFS_ALIAS: rd_val = alias_addr[port_idx];
         OFS_PORT0_ADDR: rd_val = paddr[0];
         OFS_PORT1_ADDR: rd_val = paddr[1];
         default: rd_val = 8'h00;
      endcase
   end

   // byte-level target sequencer and register writes
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_tx = tx;
      next_ptr = ptr;
      next_first = first;
      next_ptr_phase = ptr_phase;
      next_rd = rd;
      next_fwd = fwd;
      next_ack = ack;
      next_via_pp = via_pp;
      next_pp_idx = pp_idx;
      next_after_send = after_send;
      next_req = 1'b0;
      next_fwd_data = FWD;
      next_prim = prim;
      next_gen = gen;
      next_psel = psel;
      next_bcc = bcc;
      next_alias = alias_addr;
      next_paddr = paddr;
      if (strap_load) begin
         next_prim = strap_addr;
      end
      if (start_det) begin
         // repeated start keeps the pointer for combined reads
         next_state = ST_RECV;
         next_cnt = 4'h0;
         next_first = 1'b1;
      end else if (stop_det) begin
         next_state = ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
            end
            ST_RECV: begin
               if (rise) begin
                  next_sh = {sh[6:0], sda_s};
                  next_cnt = cnt + 4'h1;
               end else if (fall && cnt == BITS_PER_BYTE) begin
                  next_cnt = 4'h0;
                  next_ack = 1'b1;
                  if (first) begin
                     next_first = 1'b0;
                     next_rd = sh[0];
                     if (addr_hit(sh, prim) || addr_hit(sh, paddr[0])
                         || addr_hit(sh, paddr[1])) begin
                        next_fwd = 1'b0;
                        next_via_pp = !addr_hit(sh, prim);
                        next_pp_idx = addr_hit(sh, paddr[1]);
                        next_ptr_phase = 1'b1;
                        next_state = ST_ACK;
                     end else if (addr_hit(sh, alias_addr[sel_port])
                         && bcc[sel_port][BCC_PASS_BIT]
                         && PORT_LOCK[sel_port]) begin
                        next_fwd = 1'b1;
                        next_req = 1'b1;
                        next_fwd_data = '{sel_port, 1'b1, 1'b0, sh};
                        next_after_send = 1'b0;
                        next_state = ST_WAIT;
                     end else begin
                        next_state = ST_IDLE;
                     end
                  end else if (fwd) begin
                     next_req = 1'b1;
                     next_fwd_data = '{sel_port, 1'b0, 1'b0, sh};
                     next_after_send = 1'b0;
                     next_state = ST_WAIT;
                  end else begin
                     next_state = ST_ACK;
                     if (ptr_phase) begin
                        next_ptr_phase = 1'b0;
                        next_ptr = sh;
                     end else begin
                        next_ptr = ptr + 8'h01;
                        case (ptr)
                           OFS_PRIMARY: next_prim = sh;
                           OFS_GENERAL: next_gen = sh;
                           OFS_PORT_SEL: next_psel = sh;
                           OFS_BACK_CHAN: next_bcc[port_idx] = sh;
                           OFS_ALIAS: next_alias[port_idx] = sh;
                           OFS_PORT0_ADDR: next_paddr[0] = sh;
                           OFS_PORT1_ADDR: next_paddr[1] = sh;
                           default: ;
                        endcase
                     end
                  end
               end
            end
            ST_ACK, ST_MACK: begin
               if (state == ST_MACK && rise) begin
                  next_ack = !sda_s;
               end else if (fall) begin
                  next_cnt = 4'h0;
                  if (!ack) begin
                     next_state = ST_IDLE;
                  end else if (rd && fwd) begin
                     next_req = 1'b1;
                     next_fwd_data = '{sel_port, 1'b0, 1'b1, 8'h00};
                     next_after_send = 1'b1;
                     next_state = ST_WAIT;
                  end else if (rd) begin
                     next_tx = rd_val;
                     next_ptr = ptr + 8'h01;
                     next_state = ST_SEND;
                  end else begin
                     next_state = ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (fall) begin
                  next_tx = {tx[6:0], 1'b1};
                  next_cnt = cnt + 4'h1;
                  if (cnt == BITS_PER_BYTE - 4'h1) begin
                     next_state = ST_MACK;
                  end
               end
            end
            ST_WAIT: begin
               // scl is held low here until the far end answers
               if (FWD_DONE) begin
                  next_ack = FWD_ACK;
                  next_tx = FWD_RDATA;
                  next_cnt = 4'h0;
                  next_state = after_send ? ST_SEND : ST_ACK;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'hFF;
         ptr <= 8'h00;
         first <= 1'b0;
         ptr_phase <= 1'b0;
         rd <= 1'b0;
         fwd <= 1'b0;
         ack <= 1'b0;
         via_pp <= 1'b0;
         pp_idx <= 1'b0;
         after_send <= 1'b0;
         FWD_REQ <= 1'b0;
         FWD <= '0;
         prim <= RST_PRIMARY;
         gen <= RST_GENERAL;
         psel <= RST_PORT_SEL;
         bcc <= '{RST_BACK_CHAN, RST_BACK_CHAN};
         alias_addr <= '{RST_ALIAS, RST_ALIAS};
         paddr <= '{RST_PORT_ADDR, RST_PORT_ADDR};
      end else if (CE) begin
         state <= next_state;
         scl_q <= scl_s;
         sda_q <= sda_s;
         cnt <= next_cnt;
         sh <= next_sh;
         tx <= next_tx;
         ptr <= next_ptr;
         first <= next_first;
         ptr_phase <= next_ptr_phase;
         rd <= next_rd;
         fwd <= next_fwd;
         ack <= next_ack;
         via_pp <= next_via_pp;
         pp_idx <= next_pp_idx;
         after_send <= next_after_send;
         FWD_REQ <= next_req;
         FWD <= next_fwd_data;
         prim <= next_prim;
         gen <= next_gen;
         psel <= next_psel;
         bcc <= next_bcc;
         alias_addr <= next_alias;
         paddr <= next_paddr;
      end
   end

   // open-drain pins only ever pull low
   assign SDA_OUT = 1'b0;
   assign SCL_OUT = 1'b0;
   assign SDA_OE = (state == ST_ACK && ack) || (state == ST_SEND && !tx[7]);
   assign SCL_OE = (state == ST_WAIT);
   assign PROXY_EN = gen[GEN_PROXY_BIT];

   // ----------------------------------------------------------------
   // back-channel side information
   // ----------------------------------------------------------------
   logic [GPIO_W-1:0] next_gpio;
   logic [7:0] next_caps;
   logic [1:0] next_rate;

   // strap gives the default rate, the per-port field overrides it
   always_comb begin
      next_gpio = gpio_s;
      next_caps = CAPS;
      for (int p = 0; p < 2; p++) begin
         unique case (bcc[p][BCC_RATE_MSB:BCC_RATE_LSB])
            RATE_FAST: next_rate[p] = 1'b1;
            RATE_SLOW: next_rate[p] = 1'b0;
            default: next_rate[p] = mode_s;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BC_GPIO <= '0;
         BC_CAPS <= 8'h00;
         BC_RATE_FAST <= 2'h0;
      end else if (CE) begin
         BC_GPIO <= next_gpio;
         BC_CAPS <= next_caps;
         BC_RATE_FAST <= next_rate;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_local_no_stretch: assert property (@(posedge CLK)
      disable iff (SYS_RST) SCL_OE |-> fwd)
      else $error("clock held low during a local access");
   chk_remote_stretch: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      FWD_REQ |-> SCL_OE && state == ST_WAIT)
      else $error("clock released before remote answer");
   chk_proxy_enable: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      $changed(PROXY_EN) && CE |-> $past(state) == ST_RECV
         && $past(ptr) == OFS_GENERAL)
      else $error("proxy enable changed without a write");
   chk_pass_through: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      FWD_REQ |-> bcc[FWD.port][BCC_PASS_BIT])
      else $error("forwarded with pass-through clear");
   chk_nack_unmatched: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      state == ST_RECV && first && fall && cnt == BITS_PER_BYTE && CE
      && !start_det && !stop_det && next_state == ST_IDLE
      |=> !SDA_OE [*2])
      else $error("unmatched address acknowledged");
   chk_rate_override: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      CE && bcc[0][BCC_RATE_MSB:BCC_RATE_LSB] == RATE_SLOW
      |=> ##1 !BC_RATE_FAST[0] || !CE)
      else $error("rate override ignored");
   chk_open_drain: assert property (@(posedge CLK)
      disable iff (SYS_RST) !SDA_OUT && !SCL_OUT)
      else $error("pin driven high");
   chk_strap_to_primary: assert property (@(posedge CLK)
      disable iff (SYS_RST)
      strap_load && CE |=> prim == $past(strap_addr))
      else $error("primary address not stored");
endmodule

/* File: far_end_model.sv */
`timescale 1ns/1ps
// -----------------------------------------
// far end of the link: answers one byte at a time
// -----------------------------------------
module far_end_model (
   input wire logic CLK,
   input wire logic FWD_REQ,
   input wire hub_i2c_pkg::fwd_req_type FWD,
   input wire logic [7:0] DELAY,
   output logic FWD_DONE,
   output logic FWD_ACK,
   output logic [7:0] FWD_RDATA,
   output hub_i2c_pkg::fwd_req_type LAST
);
   import hub_i2c_pkg::*;
   int n = -1;
   initial begin
      FWD_DONE = 1'b0;
      FWD_ACK = 1'b0;
      FWD_RDATA = 8'hA5;
      LAST = '0;
   end
   // answer lines mean nothing outside the done pulse, so they toggle
   always @(posedge CLK) begin
      FWD_DONE <= 1'b0;
      FWD_ACK <= ~FWD_ACK;
      FWD_RDATA <= ~FWD_RDATA;
      if (FWD_REQ) begin
         LAST <= FWD;
         n <= DELAY;
      end else if (n == 0) begin
         FWD_DONE <= 1'b1;
         FWD_ACK <= 1'b1;
         n <= -1;
      end else if (n > 0) begin
         n <= n - 1;
      end
   end
endmodule

/* File: tb_hub_i2c_control_port.sv */
`timescale 1ns/1ps
module tb_hub_i2c_control_port;
   import hub_i2c_pkg::*;
   // -----------------------------------------
   // pins, wired-and bus and counters
   // -----------------------------------------
   logic CLK = 0, SYS_RST = 1, pdr = 0, mode = 0, done, ack, pen;
   logic scl_l = 0, sda_l = 0, scl_oe, sda_oe, req;
   logic [2:0] idx = 0;
   logic [1:0] lock = 0, rate;
   logic [3:0] gpio = 0, bgpio;
   logic [7:0] rdat, caps, dly = 0;
   fwd_req_type fwd, last;
   int n_fail = 0, check_count = 0, stretch = 0, seed = 32'h8BDC;
   logic [7:0] mem [logic [7:0]];
   wire scl_w = !(scl_l | scl_oe);
   wire sda_w = !(sda_l | sda_oe);
   initial forever #10 CLK = ~CLK;
   // cycles the device holds the clock low
   always @(posedge CLK) if (scl_oe) stretch <= stretch + 1;
   hub_i2c_control_port #(.STRAP_WAIT(20)) u_hub_i2c_control_port (
      .CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1), .SCL_IN(scl_w),
      .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(),
      .SDA_OE(sda_oe), .POWER_DOWN_RELEASE_PIN(pdr),
      .ADDRESS_STRAP_PIN(idx), .MODE_STRAP_PIN(mode), .PORT_LOCK(lock),
      .GPIO_IN(gpio), .FWD_REQ(req), .FWD(fwd), .FWD_DONE(done),
      .FWD_ACK(ack), .FWD_RDATA(rdat), .BC_GPIO(bgpio), .BC_CAPS(caps),
      .BC_RATE_FAST(rate), .PROXY_EN(pen));
   far_end_model u_far_end_model (.CLK(CLK), .FWD_REQ(req), .FWD(fwd),
      .DELAY(dly), .FWD_DONE(done), .FWD_ACK(ack), .FWD_RDATA(rdat),
      .LAST(last));
   task automatic hc(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic chk(input string s, input logic [7:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one bit of 160 ns; waits out a stretch but never forever
   task automatic bit_io(input logic b, output logic s);
      int n = 0;
      sda_l = !b;
      hc(2);
      scl_l = 0;
      while (!scl_w && n < 3000) begin
         hc(1);
         n++;
      end
      if (n == 3000) begin
         n_fail++;
         finish_test();
      end
      hc(2);
      s = sda_w;
      hc(2);
      scl_l = 1;
      hc(2);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      a = !s;
   endtask
   task automatic rbyte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
   endtask
   // also serves as repeated start
   task automatic start();
      sda_l = 0;
      hc(2);
      scl_l = 0;
      hc(4);
      sda_l = 1;
      hc(4);
      scl_l = 1;
      hc(2);
   endtask
   task automatic stop();
      sda_l = 1;
      hc(2);
      scl_l = 0;
      hc(4);
      sda_l = 0;
      hc(4);
   endtask
   task automatic wr(input logic [7:0] adr, p, d);
      logic [2:0] a;
      start();
      wbyte(adr, a[2]);
      wbyte(p, a[1]);
      wbyte(d, a[0]);
      stop();
      chk("write acks", {5'h0, a}, 8'h07);
      mem[p] = d;
   endtask
   task automatic rd(input logic [7:0] adr, p, output logic [7:0] d);
      logic [2:0] a;
      start();
      wbyte(adr, a[2]);
      wbyte(p, a[1]);
      start();
      wbyte(adr | 8'h01, a[0]);
      rbyte(d);
      stop();
      chk("read acks", {5'h0, a}, 8'h07);
   endtask
   initial begin
      logic [6:0] tbl [8] = '{7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h3A,
         7'h3C, 7'h3D};
      logic [7:0] pa, v;
      logic [7:0] dl [2] = '{8'h00, 8'h3C};
      logic a;
      int r, s0;
      hc(10);
      SYS_RST = 0;
      r = $random(seed);
      idx = r[2:0];
      pdr = 1;
      hc(40);
      pa = {tbl[idx], 1'b0};
      s0 = stretch;
      rd(pa, OFS_PRIMARY, v);
      chk("primary address", v, pa);
      wr(pa, OFS_GENERAL, 8'h20);
      hc(6);
      chk("proxy enable", {7'h0, pen}, 8'h01);
      rd(pa, OFS_GENERAL, v);
      chk("general config", v, mem[OFS_GENERAL]);
      chk("local stretch", 8'(stretch - s0), 8'h00);
      start();
      wbyte(pa ^ 8'h80, a);
      stop();
      chk("stray address ack", {7'h0, a}, 8'h00);
      $display("test local done");
      wr(pa, OFS_PORT0_ADDR, 8'h42);
      wr(pa, OFS_PORT1_ADDR, 8'h44);
      rd(8'h42, OFS_GENERAL, v);
      chk("shared via port0", v, mem[OFS_GENERAL]);
      rd(8'h44, OFS_PORT0_ADDR, v);
      chk("shared via port1", v, mem[OFS_PORT0_ADDR]);
      wr(8'h44, OFS_BACK_CHAN, {6'h0, RATE_FAST});
      hc(4);
      chk("rates", {6'h0, rate}, 8'h02);
      r = $random(seed);
      gpio = r[3:0];
      hc(5);
      chk("gpio", {4'h0, bgpio}, {4'h0, gpio});
      chk("caps", caps, 8'h5A);
      $display("test ports done");
      lock = 2'b11;
      wr(pa, OFS_PORT_SEL, 8'h00);
      wr(pa, OFS_ALIAS, 8'hA0);
      wr(pa, OFS_BACK_CHAN, 8'h40);
      // a prompt and a slow far end
      for (int i = 0; i < 2; i++) begin
         dly = dl[i];
         s0 = stretch;
         r = $random(seed);
         start();
         wbyte(8'hA0, a);
         chk("remote addr ack", {7'h0, a}, 8'h01);
         chk("head", {last.port, last.start, last.read, 5'h0}, 8'h40);
         chk("head byte", last.data, 8'hA0);
         wbyte(r[7:0], a);
         stop();
         chk("remote byte", last.data, r[7:0]);
         chk("stretched", {7'h0, (stretch - s0) > int'(dly)}, 8'h01);
      end
      wr(pa, OFS_BACK_CHAN, 8'h00);
      start();
      wbyte(8'hA0, a);
      stop();
      chk("no pass ack", {7'h0, a}, 8'h00);
      $display("test forward done");
      finish_test();
   end
endmodule
